/* probe_pkg.sv */
// Purpose: Shared constants for the dual probe position latch
// Assumes: Object indices are the register addresses on the object port
// Notes: Channel two fields sit eight bits above channel one fields
package probe_pkg;

   // ----------------------------------------
   // Object indices
   // ----------------------------------------
   localparam logic [15:0] IDX_ONE_SOURCE = 16'h44b0;
   localparam logic [15:0] IDX_TWO_SOURCE = 16'h44b1;
   localparam logic [15:0] IDX_CONTROL = 16'h60b8;
   localparam logic [15:0] IDX_STATUS = 16'h60b9;
   localparam logic [15:0] IDX_ONE_RISE = 16'h60ba;
   localparam logic [15:0] IDX_ONE_FALL = 16'h60bb;
   localparam logic [15:0] IDX_TWO_RISE = 16'h60bc;
   localparam logic [15:0] IDX_TWO_FALL = 16'h60bd;

   // ----------------------------------------
   // Field positions within a channel byte
   // ----------------------------------------
   localparam int CH_STRIDE = 8;
   localparam int BIT_ARM = 0;
   localparam int BIT_MODE = 1;
   localparam int BIT_TRIG_SEL = 2;
   localparam int BIT_RISE_EN = 4;
   localparam int BIT_FALL_EN = 5;
   localparam int BIT_ST_ENABLED = 0;
   localparam int BIT_ST_RISE = 1;
   localparam int BIT_ST_FALL = 2;

   // Writable control bits; reserved bits 3, 6, 7, 11, 14, 15 are zero
   localparam logic [15:0] CONTROL_MASK = 16'h3737;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic SOURCE_RESET = 1'h0;
   localparam logic [31:0] CAPTURE_RESET = 32'h0000_0000;

endpackage : probe_pkg

/* probe_sync.sv */
// Purpose: Two-stage synchroniser for an asynchronous level
// Assumes: Input comes from a pin outside the sys_clk domain
// Notes: Only the second stage is read outside this module
`timescale 1ns/1ps
module probe_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Level
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic first;
      logic second;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   always_comb begin
      st_nxt.first = async_in;
      st_nxt.second = st_r.first;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.second;
endmodule : probe_sync

/* probe_channel.sv */
// Purpose: One capture channel: arm, edge detect, latch rising and falling
// Assumes: Trigger inputs already synchronised to sys_clk
// Notes: Control byte configuration is frozen at the arming edge; the source bit is used live
`timescale 1ns/1ps
module probe_channel #(
   parameter int POS_W = 32
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Settings from the control word and the source object
   input wire logic [7:0] ctrl_byte,
   input wire logic pos_source,
   // Triggers and positions
   input wire logic latch_in,
   input wire logic zero_phase,
   input wire logic [POS_W-1:0] feedback_pos,
   input wire logic [POS_W-1:0] command_pos,
   // Results
   output logic [2:0] status_bits,
   output logic [POS_W-1:0] rise_capture,
   output logic [POS_W-1:0] fall_capture
);
   // Elaboration-time check of the position width
   if (POS_W < 1) begin : g_bad_width
      $error("POS_W must be positive");
   end

   typedef struct packed {
      logic armed;
      logic mode;
      logic trig_sel;
      logic rise_en;
      logic fall_en;
      logic trig_prev;
      logic rise_flag;
      logic fall_flag;
      logic [POS_W-1:0] rise_pos;
      logic [POS_W-1:0] fall_pos;
   } chan_state_t;

   chan_state_t st_r;
   chan_state_t st_nxt;

   logic trig;
   logic [POS_W-1:0] pos;
   logic arm_req;

   always_comb begin
      st_nxt = st_r;
      arm_req = ctrl_byte[probe_pkg::BIT_ARM];
      // Applied selection chooses the trigger
      trig = st_r.trig_sel ? zero_phase : latch_in;
      // Zero-phase trigger always takes feedback
      pos = (!st_r.trig_sel && pos_source) ? command_pos : feedback_pos;
      st_nxt.trig_prev = trig;
      if (arm_req && !st_r.armed) begin
         // Snapshot configuration at the arming edge
         st_nxt.armed = 1'b1;
         st_nxt.mode = ctrl_byte[probe_pkg::BIT_MODE];
         st_nxt.trig_sel = ctrl_byte[probe_pkg::BIT_TRIG_SEL];
         st_nxt.rise_en = ctrl_byte[probe_pkg::BIT_RISE_EN];
         st_nxt.fall_en = ctrl_byte[probe_pkg::BIT_FALL_EN];
         st_nxt.trig_prev = ctrl_byte[probe_pkg::BIT_TRIG_SEL] ? zero_phase : latch_in;
      end else if (!arm_req) begin
         st_nxt.armed = 1'b0;
         st_nxt.rise_flag = 1'b0;
         st_nxt.fall_flag = 1'b0;
      end else begin
         // Armed: control writes ignored, edges follow snapshot, source bit used live
         if (st_r.rise_en && trig && !st_r.trig_prev
             && (st_r.mode || !st_r.rise_flag)) begin
            st_nxt.rise_pos = pos;
            st_nxt.rise_flag = 1'b1;
         end
         if (st_r.fall_en && !trig && st_r.trig_prev
             && (st_r.mode || !st_r.fall_flag)) begin
            st_nxt.fall_pos = pos;
            st_nxt.fall_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign status_bits = {st_r.fall_flag, st_r.rise_flag, st_r.armed};
   assign rise_capture = st_r.rise_pos;
   assign fall_capture = st_r.fall_pos;
endmodule : probe_channel

/* dual_probe_position_latch.sv */
// Purpose: Two-channel position latch reached through the object port
// Assumes: Host writes and reads objects by index, one object per cycle
// Notes: Read data is registered one cycle after the read strobe
//
// Overview of operation
// - Two channels record position on trigger
// - Source bit: 0 feedback, 1 command
// - Channel one low byte, two high byte
// - Arming on 0 to 1 applies configuration
// - Control writes ignored while channel armed; source writes act at once
// - Mode 0 latches first trigger only
// - Mode 1 overwrites on every trigger
// - Channel one trigger: input one or zero-phase
// - Channel two trigger: input two or zero-phase
// - Rising edge enable stores positive capture
// - Falling edge enable stores negative capture
// - Four read-only signed 32-bit captures
// - Status word reports enabled and latch flags
// - Zero-phase trigger always captures feedback position
`timescale 1ns/1ps
module dual_probe_position_latch #(
   parameter int POS_W = 32
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Object port
   input wire logic obj_wr,
   input wire logic obj_rd,
   input wire logic [15:0] obj_index,
   input wire logic [31:0] obj_wdata,
   output logic [31:0] obj_rdata,
   output logic obj_rvalid,
   output logic obj_err,
   // Pins
   input wire logic external_latch_in_one,
   input wire logic external_latch_in_two,
   // Internal signals of the driver
   input wire logic zero_phase_signal,
   input wire logic [POS_W-1:0] feedback_pos,
   input wire logic [POS_W-1:0] command_pos
);
   // Elaboration-time check: capture objects are fixed at 32 bits
   if (POS_W != 32) begin : g_bad_width
      $error("Capture objects are 32 bits wide");
   end

   typedef struct packed {
      logic [15:0] control;
      logic [1:0] source;
      logic [31:0] rdata;
      logic rvalid;
      logic err;
   } top_state_t;

   top_state_t st_r;
   top_state_t st_nxt;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [1:0] latch_pins;
   logic [1:0] latch_sync;
   assign latch_pins = {external_latch_in_two, external_latch_in_one};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         probe_sync u_sync (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .async_in(latch_pins[gi]),
            .sync_out(latch_sync[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Capture channels
   // ----------------------------------------
   logic [2:0] ch_status [2];
   logic [POS_W-1:0] ch_rise [2];
   logic [POS_W-1:0] ch_fall [2];

   generate
      for (gi = 0; gi < 2; gi++) begin : g_chan
         probe_channel #(.POS_W(POS_W)) u_chan (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .ctrl_byte(st_r.control[gi*probe_pkg::CH_STRIDE +: 8]),
            .pos_source(st_r.source[gi]),
            .latch_in(latch_sync[gi]),
            .zero_phase(zero_phase_signal),
            .feedback_pos(feedback_pos),
            .command_pos(command_pos),
            .status_bits(ch_status[gi]),
            .rise_capture(ch_rise[gi]),
            .fall_capture(ch_fall[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Object access
   // ----------------------------------------
   logic [15:0] status_word;
   assign status_word = {5'h00, ch_status[1], 5'h00, ch_status[0]};

   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = obj_rd;
      st_nxt.err = 1'b0;
      if (obj_wr) begin
         unique case (obj_index)
            probe_pkg::IDX_CONTROL: begin
               st_nxt.control = obj_wdata[15:0] & probe_pkg::CONTROL_MASK;
            end
            probe_pkg::IDX_ONE_SOURCE: begin
               st_nxt.source[0] = obj_wdata[0];
            end
            probe_pkg::IDX_TWO_SOURCE: begin
               st_nxt.source[1] = obj_wdata[0];
            end
            default: begin
               st_nxt.err = 1'b1;
            end
         endcase
      end
      if (obj_rd) begin
         st_nxt.rdata = 32'h0000_0000;
         unique case (obj_index)
            probe_pkg::IDX_CONTROL: st_nxt.rdata = {16'h0000, st_r.control};
            probe_pkg::IDX_ONE_SOURCE: st_nxt.rdata = {31'h0, st_r.source[0]};
            probe_pkg::IDX_TWO_SOURCE: st_nxt.rdata = {31'h0, st_r.source[1]};
            probe_pkg::IDX_STATUS: st_nxt.rdata = {16'h0000, status_word};
            probe_pkg::IDX_ONE_RISE: st_nxt.rdata = ch_rise[0];
            probe_pkg::IDX_ONE_FALL: st_nxt.rdata = ch_fall[0];
            probe_pkg::IDX_TWO_RISE: st_nxt.rdata = ch_rise[1];
            probe_pkg::IDX_TWO_FALL: st_nxt.rdata = ch_fall[1];
            default: st_nxt.err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r.control <= probe_pkg::CONTROL_RESET;
         st_r.source <= {2{probe_pkg::SOURCE_RESET}};
         st_r.rdata <= probe_pkg::CAPTURE_RESET;
         st_r.rvalid <= 1'b0;
         st_r.err <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign obj_rdata = st_r.rdata;
   assign obj_rvalid = st_r.rvalid;
   assign obj_err = st_r.err;
endmodule : dual_probe_position_latch

/* probe_sva.sv */
// Purpose: Port checks for the dual probe latch
// Assumes: Object strobes are one-cycle pulses
// Notes: Bound to the top module
`timescale 1ns/1ps
module probe_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Object port
   input wire logic obj_wr,
   input wire logic obj_rd,
   input wire logic [15:0] obj_index,
   input wire logic [31:0] obj_wdata,
   input wire logic [31:0] obj_rdata,
   input wire logic obj_rvalid,
   input wire logic obj_err
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   localparam logic [15:0] CI = probe_pkg::IDX_CONTROL;
   property p_rd_valid; obj_rd && obj_index == CI |=> obj_rvalid; endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("no read answer");
   property p_no_valid; !obj_rd |=> !obj_rvalid; endproperty
   a_no_valid: assert property (p_no_valid) else $error("stray read answer");
   property p_ctrl_rsv;
      obj_rd && obj_index == CI |=> (obj_rdata & ~{16'h0, probe_pkg::CONTROL_MASK}) == 32'h0;
   endproperty
   a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bit set");
   property p_ctrl_back;
      obj_wr && obj_index == CI ##1 !obj_wr ##1 obj_rd && !obj_wr && obj_index == CI
         |=> obj_rdata[15:0] == ($past(obj_wdata[15:0], 3) & probe_pkg::CONTROL_MASK);
   endproperty
   a_ctrl_back: assert property (p_ctrl_back) else $error("control readback");
   property p_stat_rsv;
      obj_rd && obj_index == probe_pkg::IDX_STATUS |=> (obj_rdata & 32'hffff_f8f8) == 32'h0;
   endproperty
   a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bit");
   property p_ro_err; obj_wr && obj_index == probe_pkg::IDX_TWO_FALL |=> obj_err; endproperty
   a_ro_err: assert property (p_ro_err) else $error("read-only write accepted");
   property p_ok_noerr; obj_rd && !obj_wr && obj_index == CI |=> !obj_err; endproperty
   a_ok_noerr: assert property (p_ok_noerr) else $error("error on valid read");
   property p_src_rd;
      obj_rd && obj_index == probe_pkg::IDX_ONE_SOURCE |=> obj_rdata[31:1] == 31'h0;
   endproperty
   a_src_rd: assert property (p_src_rd) else $error("source wider than a bit");
endmodule : probe_sva
bind dual_probe_position_latch probe_sva probe_sva_inst (.sys_clk, .sys_rst, .obj_wr,
   .obj_rd, .obj_index, .obj_wdata, .obj_rdata, .obj_rvalid, .obj_err);

/* probe_host.sv */
// Purpose: Host side of the object port
// Assumes: One object access at a time
// Notes: Write data is scrambled once a write is over
`timescale 1ns/1ps
module probe_host (
   // Clock
   input wire logic sys_clk,
   // Object port
   output logic obj_wr,
   output logic obj_rd,
   output logic [15:0] obj_index,
   output logic [31:0] obj_wdata,
   input wire logic [31:0] obj_rdata,
   input wire logic obj_rvalid
);
   initial begin
      obj_wr = 1'h0;
      obj_rd = 1'h0;
      obj_index = 16'h0;
      obj_wdata = 32'h0;
   end
   task automatic put(input logic [15:0] idx, input logic [31:0] d);
      @(posedge sys_clk);
      obj_wr <= 1'h1;
      obj_index <= idx;
      obj_wdata <= d;
      @(posedge sys_clk);
      obj_wr <= 1'h0;
      obj_wdata <= ~d;
   endtask : put
   task automatic get(input logic [15:0] idx, output logic [31:0] d, output logic ok);
      @(posedge sys_clk);
      obj_rd <= 1'h1;
      obj_index <= idx;
      @(posedge sys_clk);
      obj_rd <= 1'h0;
      #1;
      ok = obj_rvalid;
      d = obj_rdata;
   endtask : get
   // New trigger settings always go through a disarm first
   task automatic rearm(input logic [15:0] v);
      put(probe_pkg::IDX_CONTROL, 32'h0);
      put(probe_pkg::IDX_CONTROL, {16'h0, v});
   endtask : rearm
endmodule : probe_host

/* dual_probe_position_latch_bench.sv */
// Purpose: Self-checking bench for the dual probe latch
// Assumes: Pins settle within eight cycles
// Notes: Positions are random, held during each capture
`timescale 1ns/1ps
module dual_probe_position_latch_bench;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic obj_wr, obj_rd, obj_rvalid, obj_err, ok;
   logic [2:0] trig = 3'h0;
   logic [15:0] obj_index;
   logic [31:0] obj_wdata, obj_rdata, got, e1, e2;
   logic [31:0] fb = 32'h0;
   logic [31:0] cmd = 32'h0;
   int err_total = 0;
   int compares = 0;
   always #12.5 sys_clk = ~sys_clk;
   dual_probe_position_latch dual_probe_position_latch_inst (.sys_clk, .sys_rst, .obj_wr,
      .obj_rd, .obj_index, .obj_wdata, .obj_rdata, .obj_rvalid, .obj_err,
      .external_latch_in_one(trig[0]), .external_latch_in_two(trig[1]),
      .zero_phase_signal(trig[2]), .feedback_pos(fb), .command_pos(cmd));
   probe_host probe_host_inst (.sys_clk, .obj_wr, .obj_rd, .obj_index, .obj_wdata,
      .obj_rdata, .obj_rvalid);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e);
      probe_host_inst.get(idx, got, ok);
      chk({31'h0, ok}, 32'h1);
      chk(got, e);
   endtask : rd_chk
   function automatic logic [31:0] exp_pos(input logic ext, input logic src);
      return (ext && src) ? cmd : fb;
   endfunction : exp_pos
   task automatic set_trig(input logic [2:0] v);
      @(posedge sys_clk);
      trig <= v;
      repeat (8) @(posedge sys_clk);
   endtask : set_trig
   task automatic new_pos();
      @(posedge sys_clk);
      fb <= $urandom;
      cmd <= $urandom;
   endtask : new_pos
   task automatic final_report();
      $display("mismatches %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      final_report();
   end
   initial begin
      void'($urandom(32'he8507f9f));
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'h0;
      for (int i = 0; i < 8; i++) begin
         rd_chk((i < 2) ? 16'h44b0 + i[15:0] : 16'h60b6 + i[15:0], 32'h0);
      end
      probe_host_inst.put(probe_pkg::IDX_CONTROL, 32'hffff_ffff);
      rd_chk(probe_pkg::IDX_CONTROL, 32'h3737);
      for (int i = 0; i < 2; i++) begin
         probe_host_inst.put(i == 0 ? 16'h1234 : probe_pkg::IDX_TWO_FALL, 32'h5);
         #1;
         chk({31'h0, obj_err}, 32'h1);
      end
      // Zero-phase trigger, continuous, both channels
      probe_host_inst.put(probe_pkg::IDX_ONE_SOURCE, 32'h1);
      probe_host_inst.put(probe_pkg::IDX_TWO_SOURCE, 32'h1);
      probe_host_inst.rearm(16'h3737);
      for (int k = 0; k < 3; k++) begin
         new_pos();
         set_trig(3'h4);
         rd_chk(probe_pkg::IDX_ONE_RISE, exp_pos(1'h0, 1'h1));
         rd_chk(probe_pkg::IDX_TWO_RISE, exp_pos(1'h0, 1'h1));
         new_pos();
         set_trig(3'h0);
         rd_chk(probe_pkg::IDX_ONE_FALL, fb);
         rd_chk(probe_pkg::IDX_TWO_FALL, fb);
      end
      rd_chk(probe_pkg::IDX_STATUS, 32'h0707);
      probe_host_inst.put(probe_pkg::IDX_CONTROL, 32'h3331);
      new_pos();
      set_trig(3'h4);
      rd_chk(probe_pkg::IDX_TWO_RISE, fb);
      probe_host_inst.put(probe_pkg::IDX_CONTROL, 32'h0);
      rd_chk(probe_pkg::IDX_STATUS, 32'h0);
      set_trig(3'h0);
      // External pins, one-shot, rising edge only
      probe_host_inst.put(probe_pkg::IDX_TWO_SOURCE, 32'h0);
      probe_host_inst.rearm(16'h1111);
      new_pos();
      set_trig(3'h3);
      e1 = exp_pos(1'h1, 1'h1);
      e2 = exp_pos(1'h1, 1'h0);
      set_trig(3'h0);
      new_pos();
      set_trig(3'h3);
      set_trig(3'h0);
      rd_chk(probe_pkg::IDX_ONE_RISE, e1);
      rd_chk(probe_pkg::IDX_TWO_RISE, e2);
      rd_chk(probe_pkg::IDX_STATUS, 32'h0303);
      probe_host_inst.rearm(16'h1111);
      new_pos();
      set_trig(3'h1);
      rd_chk(probe_pkg::IDX_ONE_RISE, exp_pos(1'h1, 1'h1));
      final_report();
   end
endmodule : dual_probe_position_latch_bench
